// ### rtl/flsr_regs.svh
`ifndef FLSR_REGS_SVH
`define FLSR_REGS_SVH

// command opcodes
`define FLSR_OP_WRSR1 8'h01
`define FLSR_OP_WRSR2 8'h31
`define FLSR_OP_WRSR3 8'h11
`define FLSR_OP_RDSR1 8'h05
`define FLSR_OP_RDSR2 8'h35
`define FLSR_OP_RDSR3 8'h15
`define FLSR_OP_WREN 8'h06
`define FLSR_OP_WRDI 8'h04
`define FLSR_OP_VWREN 8'h50
`define FLSR_OP_SUSPEND 8'h75
`define FLSR_OP_RESUME 8'h7a
`define FLSR_OP_PP 8'h02
`define FLSR_OP_SE 8'h20
`define FLSR_OP_BE32 8'h52
`define FLSR_OP_BE64 8'hd8
`define FLSR_OP_CE1 8'hc7
`define FLSR_OP_CE2 8'h60

// field positions
`define FLSR_S1_BUSY 0
`define FLSR_S1_LATCH 1
`define FLSR_S1_BP_LSB 2
`define FLSR_S1_BP_MSB 4
`define FLSR_S1_PROT_LO 7
`define FLSR_S2_SUSPEND 7
`define FLSR_S2_COMPL 6
`define FLSR_S2_LB_MSB 5
`define FLSR_S2_LB_LSB 3
`define FLSR_S2_QUAD 1
`define FLSR_S2_PROT_HI 0
`define FLSR_S3_PINSEL 7
`define FLSR_S3_DRV_MSB 6
`define FLSR_S3_DRV_LSB 5
`define FLSR_S3_HIFREQ 4

// writable masks and reset values
`define FLSR_S1_WMASK 8'hfc
`define FLSR_S2_WMASK 8'h43
`define FLSR_S2_LBMASK 8'h38
`define FLSR_S3_WMASK 8'hf0
`define FLSR_S1_RST 8'h00
`define FLSR_S2_RST 8'h00
`define FLSR_S3_RST 8'h00

// default operation times in clk cycles
`define FLSR_T_WRSR_CYC 2000
`define FLSR_T_PP_CYC 3000
`define FLSR_T_ERASE_CYC 8000

`endif

// ### rtl/flsr_pkg.sv
package flsr_pkg;
   typedef logic [7:0] flsr_byte_type;
   typedef enum logic [1:0] {
      FLSR_ST_IDLE = 2'b00,
      FLSR_ST_BUSY = 2'b01,
      FLSR_ST_SUSP = 2'b11
   } flsr_state_type;
endpackage : flsr_pkg

// ### rtl/flsr_spi_link.sv
`timescale 1ns/10ps
module flsr_spi_link
   import flsr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire flsr_byte_type tx_byte,
   input wire logic tx_enable,
   output flsr_byte_type rx_byte,
   output logic rx_valid,
   output logic rx_first,
   output logic frame_end,
   output logic frame_whole,
   output logic miso_o,
   output logic miso_oe
);
   logic sclk_meta_q, sclk_sync_q, sclk_prev_q;
   logic cs_meta_q, cs_sync_q, cs_prev_q;
   logic mosi_meta_q, mosi_sync_q;
   logic [2:0] bit_cnt_q;
   logic [6:0] shift_q;
   logic first_q;
   logic [6:0] tx_sh_q;
   logic rise, fall;

   // two-stage synchronisers; first stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_meta_q <= 1'b0;
         sclk_sync_q <= 1'b0;
         cs_meta_q <= 1'b1;
         cs_sync_q <= 1'b1;
         mosi_meta_q <= 1'b0;
         mosi_sync_q <= 1'b0;
      end else begin
         sclk_meta_q <= sclk;
         sclk_sync_q <= sclk_meta_q;
         cs_meta_q <= cs_n;
         cs_sync_q <= cs_meta_q;
         mosi_meta_q <= mosi;
         mosi_sync_q <= mosi_meta_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_sync_q;
         cs_prev_q <= cs_sync_q;
      end
   end

   assign rise = sclk_sync_q & ~sclk_prev_q & ~cs_sync_q;
   assign fall = ~sclk_sync_q & sclk_prev_q & ~cs_sync_q;
   assign frame_end = cs_sync_q & ~cs_prev_q;
   // a frame counts only if it ended on a byte boundary
   assign frame_whole = (bit_cnt_q == 3'h0);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_cnt_q <= 3'h0;
         shift_q <= 7'h00;
         rx_byte <= 8'h00;
         rx_valid <= 1'b0;
         rx_first <= 1'b0;
         first_q <= 1'b1;
      end else begin
         rx_valid <= 1'b0;
         if (cs_sync_q) begin
            bit_cnt_q <= 3'h0;
            first_q <= 1'b1;
         end else if (rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q <= {shift_q[5:0], mosi_sync_q};
            if (bit_cnt_q == 3'h7) begin
               rx_byte <= {shift_q, mosi_sync_q};
               rx_valid <= 1'b1;
               rx_first <= first_q;
               first_q <= 1'b0;
            end
         end
      end
   end

   // mode 0: msb goes out right after the byte boundary, the rest on falling edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         miso_o <= 1'b0;
         miso_oe <= 1'b0;
         tx_sh_q <= 7'h00;
      end else if (cs_sync_q) begin
         miso_oe <= 1'b0;
      end else if (rx_valid) begin
         miso_o <= tx_byte[7];
         tx_sh_q <= tx_byte[6:0];
         miso_oe <= tx_enable;
      end else if (fall && bit_cnt_q != 3'h0) begin
         miso_o <= tx_sh_q[6];
         tx_sh_q <= {tx_sh_q[5:0], 1'b0};
      end
   end
endmodule : flsr_spi_link

// ### rtl/flsr_status_regs.sv
`timescale 1ns/10ps
`include "flsr_regs.svh"
module flsr_status_regs
   import flsr_pkg::*;
#(
   parameter int CNT_W = 24,
   parameter int T_WRSR_CYC = `FLSR_T_WRSR_CYC,
   parameter int T_PP_CYC = `FLSR_T_PP_CYC,
   parameter int T_ERASE_CYC = `FLSR_T_ERASE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic wp_n,
   output logic miso_o,
   output logic miso_oe,
   output logic busy,
   output logic write_enable_latch,
   output logic suspend_flag,
   output logic [2:0] block_protect,
   output logic complement_protect,
   output logic [2:0] secreg_lock,
   output logic quad_io_enable,
   output logic protect_mode_hi,
   output logic protect_mode_lo,
   output logic pin_function_select,
   output logic hold_pin_active,
   output logic reset_pin_active,
   output logic [1:0] drive_strength,
   output logic high_freq_mode
);
   flsr_state_type state_q;
   logic [CNT_W-1:0] cnt_q;
   logic pe_q, latch_q, vol_q;
   flsr_byte_type s1_q, s2_q, s3_q, cmd_q, d0_q, d1_q;
   logic got_cmd_q;
   logic [1:0] nbytes_q;
   logic wp_meta_q, wp_sync_q;
   flsr_byte_type rx_byte, tx_byte, op, status_one, status_two, status_three;
   logic rx_valid, rx_first, frame_end, frame_whole, tx_enable, exec_w;
   logic sr12_locked, wr_ok, nv_w;
   logic do_wren, do_wrdi, do_vwren, do_wrsr, do_pe, do_susp, do_resume;
   logic [CNT_W-1:0] pe_cyc;

   flsr_spi_link u_link (
      .clk(clk),
      .rst(rst),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .tx_byte(tx_byte),
      .tx_enable(tx_enable),
      .rx_byte(rx_byte),
      .rx_valid(rx_valid),
      .rx_first(rx_first),
      .frame_end(frame_end),
      .frame_whole(frame_whole),
      .miso_o(miso_o),
      .miso_oe(miso_oe)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_meta_q <= 1'b1;
         wp_sync_q <= 1'b1;
      end else begin
         wp_meta_q <= wp_n;
         wp_sync_q <= wp_meta_q;
      end
   end

   assign busy = (state_q == FLSR_ST_BUSY);
   assign suspend_flag = (state_q == FLSR_ST_SUSP);
   assign write_enable_latch = latch_q;
   assign status_one = {s1_q[7:2], latch_q, busy};
   assign status_two = {suspend_flag, s2_q[6:0]};
   assign status_three = s3_q;

   // reads are answered live, so polling sees busy drop mid-frame
   assign op = rx_first ? rx_byte : cmd_q;
   always_comb begin
      tx_enable = 1'b1;
      case (op)
         `FLSR_OP_RDSR1: tx_byte = status_one;
         `FLSR_OP_RDSR2: tx_byte = status_two;
         `FLSR_OP_RDSR3: tx_byte = status_three;
         default: begin
            tx_byte = 8'h00;
            tx_enable = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_q <= 8'h00;
         d0_q <= 8'h00;
         d1_q <= 8'h00;
         got_cmd_q <= 1'b0;
         nbytes_q <= 2'h0;
      end else if (frame_end) begin
         got_cmd_q <= 1'b0;
         nbytes_q <= 2'h0;
      end else if (rx_valid) begin
         if (rx_first) begin
            cmd_q <= rx_byte;
            got_cmd_q <= 1'b1;
         end else begin
            if (nbytes_q == 2'h0)
               d0_q <= rx_byte;
            if (nbytes_q == 2'h1)
               d1_q <= rx_byte;
            if (nbytes_q != 2'h3)
               nbytes_q <= nbytes_q + 2'h1;
         end
      end
   end

   assign exec_w = frame_end & frame_whole & got_cmd_q;
   // quad mode removes the protect pin from the decision
   assign sr12_locked = s2_q[`FLSR_S2_PROT_HI] |
      (s1_q[`FLSR_S1_PROT_LO] & ~wp_sync_q & ~s2_q[`FLSR_S2_QUAD]);
   assign wr_ok = latch_q | vol_q;
   assign nv_w = latch_q;

   always_comb begin
      do_wren = 1'b0;
      do_wrdi = 1'b0;
      do_vwren = 1'b0;
      do_wrsr = 1'b0;
      do_pe = 1'b0;
      do_susp = 1'b0;
      do_resume = 1'b0;
      pe_cyc = CNT_W'(T_PP_CYC);
      if (exec_w) begin
         if (state_q == FLSR_ST_BUSY) begin
            // everything else is dropped while busy
            do_susp = (cmd_q == `FLSR_OP_SUSPEND) & pe_q;
         end else if (state_q == FLSR_ST_SUSP) begin
            do_resume = (cmd_q == `FLSR_OP_RESUME);
         end else begin
            case (cmd_q)
               `FLSR_OP_WREN: do_wren = 1'b1;
               `FLSR_OP_WRDI: do_wrdi = 1'b1;
               `FLSR_OP_VWREN: do_vwren = 1'b1;
               `FLSR_OP_WRSR1, `FLSR_OP_WRSR2, `FLSR_OP_WRSR3:
                  do_wrsr = wr_ok & (nbytes_q != 2'h0);
               `FLSR_OP_PP: do_pe = latch_q;
               `FLSR_OP_SE, `FLSR_OP_BE32, `FLSR_OP_BE64,
               `FLSR_OP_CE1, `FLSR_OP_CE2: begin
                  do_pe = latch_q;
                  pe_cyc = CNT_W'(T_ERASE_CYC);
               end
               default: do_pe = 1'b0;
            endcase
         end
      end
   end

   // status write applies masked fields; busy, latch and suspend are not stored here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= `FLSR_S1_RST;
         s2_q <= `FLSR_S2_RST;
         s3_q <= `FLSR_S3_RST;
      end else if (do_wrsr) begin
         if (cmd_q == `FLSR_OP_WRSR1 && !sr12_locked)
            s1_q <= d0_q & `FLSR_S1_WMASK;
         if (!sr12_locked && ((cmd_q == `FLSR_OP_WRSR1 && nbytes_q >= 2'h2) ||
             cmd_q == `FLSR_OP_WRSR2)) begin
            // lock bits only ever set, and only by a non-volatile write
            s2_q <= ((cmd_q == `FLSR_OP_WRSR2 ? d0_q : d1_q) & `FLSR_S2_WMASK) |
               (s2_q & `FLSR_S2_LBMASK) |
               ((cmd_q == `FLSR_OP_WRSR2 ? d0_q : d1_q) & `FLSR_S2_LBMASK &
               {8{nv_w}});
         end
         if (cmd_q == `FLSR_OP_WRSR3)
            s3_q <= d0_q & `FLSR_S3_WMASK;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_q <= 1'b0;
      end else if (do_wren) begin
         latch_q <= 1'b1;
      end else if (do_wrdi | do_pe | (do_wrsr & nv_w)) begin
         latch_q <= 1'b0;
      end
   end

   // volatile enable lasts until the next executed command
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vol_q <= 1'b0;
      end else if (do_vwren) begin
         vol_q <= 1'b1;
      end else if (exec_w && state_q == FLSR_ST_IDLE) begin
         vol_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= FLSR_ST_IDLE;
         cnt_q <= '0;
         pe_q <= 1'b0;
      end else begin
         case (state_q)
            FLSR_ST_IDLE: begin
               if (do_pe) begin
                  state_q <= FLSR_ST_BUSY;
                  cnt_q <= pe_cyc;
                  pe_q <= 1'b1;
               end else if (do_wrsr && nv_w) begin
                  state_q <= FLSR_ST_BUSY;
                  cnt_q <= CNT_W'(T_WRSR_CYC);
                  pe_q <= 1'b0;
               end
            end
            FLSR_ST_BUSY: begin
               if (do_susp) begin
                  state_q <= FLSR_ST_SUSP;
               end else if (cnt_q == CNT_W'(1)) begin
                  state_q <= FLSR_ST_IDLE;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end
            end
            FLSR_ST_SUSP: begin
               if (do_resume)
                  state_q <= FLSR_ST_BUSY;
            end
            default: state_q <= FLSR_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_pin_active <= 1'b1;
         reset_pin_active <= 1'b0;
      end else begin
         hold_pin_active <= ~s2_q[`FLSR_S2_QUAD] & ~s3_q[`FLSR_S3_PINSEL];
         reset_pin_active <= ~s2_q[`FLSR_S2_QUAD] & s3_q[`FLSR_S3_PINSEL];
      end
   end

   assign block_protect = s1_q[`FLSR_S1_BP_MSB:`FLSR_S1_BP_LSB];
   assign complement_protect = s2_q[`FLSR_S2_COMPL];
   assign secreg_lock = s2_q[`FLSR_S2_LB_MSB:`FLSR_S2_LB_LSB];
   assign quad_io_enable = s2_q[`FLSR_S2_QUAD];
   assign protect_mode_hi = s2_q[`FLSR_S2_PROT_HI];
   assign protect_mode_lo = s1_q[`FLSR_S1_PROT_LO];
   assign pin_function_select = s3_q[`FLSR_S3_PINSEL];
   assign drive_strength = s3_q[`FLSR_S3_DRV_MSB:`FLSR_S3_DRV_LSB];
   assign high_freq_mode = s3_q[`FLSR_S3_HIFREQ];

   sequence s_busy_start;
      $rose(busy);
   endsequence
   sequence s_latch_off;
      !write_enable_latch;
   endsequence

   property p_latch_cleared_on_start;
      @(posedge clk) disable iff (rst) s_busy_start |-> s_latch_off;
   endproperty
   a_latch_cleared_on_start: assert property (p_latch_cleared_on_start)
      else $error("latch still set after operation start");

   property p_latch_set_cause;
      @(posedge clk) disable iff (rst) $rose(write_enable_latch) |->
         $past(exec_w) && $past(cmd_q) == `FLSR_OP_WREN;
   endproperty
   a_latch_set_cause: assert property (p_latch_set_cause)
      else $error("latch set without write enable");

   property p_reserved_zero;
      @(posedge clk) disable iff (rst) status_two[2] == 1'b0 && status_three[3:0] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bit nonzero");

   property p_lock_sticky;
      @(posedge clk) disable iff (rst) (($past(secreg_lock) & ~secreg_lock) == 3'h0);
   endproperty
   a_lock_sticky: assert property (p_lock_sticky)
      else $error("lock bit cleared");

   property p_busy_holds;
      @(posedge clk) disable iff (rst) busy && cnt_q > CNT_W'(1) && !do_susp |=> busy;
   endproperty
   a_busy_holds: assert property (p_busy_holds)
      else $error("busy dropped early");

   property p_busy_ends;
      @(posedge clk) disable iff (rst) busy && cnt_q == CNT_W'(1) && !do_susp |=> !busy[*2];
   endproperty
   a_busy_ends: assert property (p_busy_ends)
      else $error("busy not cleared on completion");

   property p_busy_ignores;
      @(posedge clk) disable iff (rst) busy && exec_w |=>
         $stable(s1_q) && $stable(s2_q) && $stable(s3_q) && $stable(write_enable_latch);
   endproperty
   a_busy_ignores: assert property (p_busy_ignores)
      else $error("command taken while busy");

   property p_wrsr_keeps_suspend;
      @(posedge clk) disable iff (rst) do_wrsr |=> !suspend_flag;
   endproperty
   a_wrsr_keeps_suspend: assert property (p_wrsr_keeps_suspend)
      else $error("status write touched suspend flag");

   property p_suspend_exclusive;
      @(posedge clk) disable iff (rst) $rose(suspend_flag) |-> $fell(busy);
   endproperty
   a_suspend_exclusive: assert property (p_suspend_exclusive)
      else $error("suspend without leaving busy");

   property p_quad_frees_pin;
      @(posedge clk) disable iff (rst) quad_io_enable |=> !hold_pin_active && !reset_pin_active;
   endproperty
   a_quad_frees_pin: assert property (p_quad_frees_pin)
      else $error("hold or reset active in quad mode");
endmodule : flsr_status_regs

// ### verification/flsr_spi_host.sv
`timescale 1ns/10ps
module flsr_spi_host (
   input wire logic clk,
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe
);
   // mode 0: clock rests low and only toggles inside a frame
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // half link period of 5 clk gives 80 ns; msb of bits goes first
   task automatic frame(input logic [39:0] bits, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      tick(1);
      cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         mosi = bits[39 - i];
         tick(5);
         sclk = 1'b1;
         rd = {rd[6:0], miso_oe ? miso_o : 1'bz};
         tick(5);
         sclk = 1'b0;
      end
      tick(5);
      cs_n = 1'b1;
      // released data line must not keep showing the last bit
      mosi = ~mosi;
      tick(10);
   endtask : frame
endmodule : flsr_spi_host

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
   import flsr_pkg::*;
   logic clk, rst, sclk, cs_n, mosi, wp_n, miso_o, miso_oe, busy, write_enable_latch;
   logic suspend_flag, complement_protect, quad_io_enable, protect_mode_hi, protect_mode_lo;
   logic pin_function_select, hold_pin_active, reset_pin_active, high_freq_mode;
   logic [2:0] block_protect, secreg_lock;
   logic [1:0] drive_strength;
   logic [7:0] v;
   int n_fail = 0;
   int checked = 0;

   flsr_spi_host host_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso_o(miso_o), .miso_oe(miso_oe));

   // long operation times shortened, still longer than one polling frame
   flsr_status_regs #(.T_WRSR_CYC(300), .T_PP_CYC(600), .T_ERASE_CYC(600)) i_flsr_status_regs (
      .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n),
      .miso_o(miso_o), .miso_oe(miso_oe), .busy(busy), .write_enable_latch(write_enable_latch),
      .suspend_flag(suspend_flag), .block_protect(block_protect),
      .complement_protect(complement_protect), .secreg_lock(secreg_lock),
      .quad_io_enable(quad_io_enable), .protect_mode_hi(protect_mode_hi),
      .protect_mode_lo(protect_mode_lo), .pin_function_select(pin_function_select),
      .hold_pin_active(hold_pin_active), .reset_pin_active(reset_pin_active),
      .drive_strength(drive_strength), .high_freq_mode(high_freq_mode));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic end_of_test();
      if (n_fail == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic cmd(input logic [7:0] op);
      host_model.frame({op, 32'h0}, 8, v);
   endtask : cmd

   task automatic wr(input logic [7:0] op, input logic [7:0] d);
      host_model.frame({op, d, 24'h0}, 16, v);
   endtask : wr

   task automatic rd(input logic [7:0] op, input logic [7:0] exp);
      host_model.frame({op, 32'h0}, 16, v);
      chk(v, exp);
   endtask : rd

   // watches busy directly, no status polling while the operation runs
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      chk(busy, 1'b0);
   endtask : wait_idle

   task automatic t_reset();
      chk({busy, write_enable_latch, suspend_flag, block_protect, complement_protect,
         secreg_lock, quad_io_enable, protect_mode_hi, protect_mode_lo, pin_function_select,
         hold_pin_active, reset_pin_active, drive_strength, high_freq_mode}, 24'h000010);
      rd(8'h05, 8'h00);
      rd(8'h35, 8'h00);
      rd(8'h15, 8'h00);
   endtask : t_reset

   task automatic t_latch();
      cmd(8'h06);
      chk(write_enable_latch, 1'b1);
      rd(8'h05, 8'h02);
      // a disable cut one bit short must be ignored
      host_model.frame({8'h04, 32'h0}, 7, v);
      chk(write_enable_latch, 1'b1);
      cmd(8'h04);
      chk(write_enable_latch, 1'b0);
   endtask : t_latch

   task automatic t_suspend();
      cmd(8'h06);
      host_model.frame({8'h20, 24'h001000, 8'h0}, 32, v);
      chk({busy, write_enable_latch}, 2'b10);
      cmd(8'h06);
      chk(write_enable_latch, 1'b0);
      cmd(8'h75);
      chk({suspend_flag, busy}, 2'b10);
      rd(8'h35, 8'h80);
      cmd(8'h7a);
      chk({suspend_flag, busy}, 2'b01);
      wait_idle();
   endtask : t_suspend

   task automatic t_status_one();
      cmd(8'h06);
      wr(8'h01, 8'h1f);
      chk({busy, write_enable_latch}, 2'b10);
      rd(8'h05, 8'h1d);
      wait_idle();
      chk(block_protect, 3'b111);
      rd(8'h05, 8'h1c);
   endtask : t_status_one

   task automatic t_volatile();
      cmd(8'h50);
      wr(8'h31, 8'hfe);
      chk({busy, suspend_flag, complement_protect, quad_io_enable}, 4'b0011);
      chk({hold_pin_active, reset_pin_active}, 2'b00);
      rd(8'h35, 8'h42);
      cmd(8'h50);
      wr(8'h11, 8'hff);
      chk({pin_function_select, drive_strength, high_freq_mode}, 4'hf);
      chk({hold_pin_active, reset_pin_active}, 2'b00);
      rd(8'h15, 8'hf0);
      cmd(8'h50);
      wr(8'h31, 8'h00);
      chk({hold_pin_active, reset_pin_active, quad_io_enable}, 3'b010);
      cmd(8'h50);
      wr(8'h11, 8'h2f);
      chk({pin_function_select, drive_strength, high_freq_mode}, 4'h2);
      chk({hold_pin_active, reset_pin_active}, 2'b10);
      rd(8'h15, 8'h20);
   endtask : t_volatile

   task automatic t_locks();
      cmd(8'h06);
      wr(8'h31, 8'h10);
      wait_idle();
      chk(secreg_lock, 3'b010);
      cmd(8'h06);
      wr(8'h31, 8'h28);
      wait_idle();
      chk(secreg_lock, 3'b111);
      // one-time bits survive a write of zeros
      cmd(8'h06);
      wr(8'h31, 8'h00);
      wait_idle();
      rd(8'h35, 8'h38);
   endtask : t_locks

   task automatic t_program();
      logic [7:0] ops [4] = '{8'h52, 8'hd8, 8'hc7, 8'h60};
      // program without the latch must not start
      host_model.frame({8'h02, 24'h000100, 8'ha5}, 40, v);
      chk(busy, 1'b0);
      cmd(8'h06);
      host_model.frame({8'h02, 24'h000100, 8'ha5}, 40, v);
      chk({busy, write_enable_latch}, 2'b10);
      wait_idle();
      for (int i = 0; i < 4; i++) begin
         cmd(8'h06);
         host_model.frame({ops[i], 32'h0}, 32, v);
         chk({busy, write_enable_latch}, 2'b10);
         wait_idle();
      end
      // two data bytes reach status_two as well
      cmd(8'h06);
      host_model.frame({8'h01, 8'h00, 8'h40, 16'h0}, 24, v);
      chk({busy, write_enable_latch}, 2'b10);
      // suspend only holds for program or erase
      cmd(8'h75);
      chk({suspend_flag, busy}, 2'b01);
      wait_idle();
      rd(8'h35, 8'h78);
   endtask : t_program

   task automatic t_protect();
      cmd(8'h50);
      wr(8'h01, 8'h80);
      chk({protect_mode_lo, block_protect}, 4'h8);
      wp_n = 1'b0;
      cmd(8'h50);
      wr(8'h01, 8'h84);
      chk(block_protect, 3'b000);
      wp_n = 1'b1;
      cmd(8'h50);
      wr(8'h01, 8'h84);
      chk(block_protect, 3'b001);
      cmd(8'h50);
      wr(8'h31, 8'h01);
      chk(protect_mode_hi, 1'b1);
      cmd(8'h50);
      wr(8'h31, 8'h40);
      chk(complement_protect, 1'b0);
      rd(8'h35, 8'h39);
   endtask : t_protect

   initial begin
      rst = 1'b1;
      wp_n = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      host_model.tick(4);
      t_reset();
      t_latch();
      t_suspend();
      t_status_one();
      t_volatile();
      t_locks();
      t_program();
      t_protect();
      end_of_test();
   end

   // whole run takes roughly 15000 clk
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
endmodule : testbench
